//--- design/fse_div_unit.sv
// Shared radix-2 divide occupancy tracker
`timescale 1ns/100ps
`default_nettype none

module fse_div_unit
  import fse_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic start_thread,
  input wire logic [7:0] start_lat,
  output logic free,
  output logic owner
);

  logic [7:0] cnt;

  // ----------------------------------------
  // Occupancy countdown
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      free <= 1'b1;
    end else if (start) begin
      cnt <= start_lat - 8'h01;
      free <= (start_lat == 8'h01);
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      free <= (cnt == 8'h01);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      owner <= 1'b0;
    end else if (start) begin
      owner <= start_thread;
    end
  end

endmodule : fse_div_unit

`default_nettype wire

//--- design/fse_exec_timing.sv
// Issue timing, unit reservation, result scoreboard and event counts of the FP/vector cluster
`timescale 1ns/100ps
`default_nettype none


module fse_exec_timing
  import fse_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [1:0] iss_valid,
  input wire fse_op_t iss_class0,
  input wire fse_op_t iss_class1,
  input wire logic iss_thread0,
  input wire logic iss_thread1,
  input wire logic [3:0] iss_dest0,
  input wire logic [3:0] iss_dest1,
  input wire logic [6:0] iss_div_bits0,
  input wire logic [6:0] iss_div_bits1,
  input wire logic float_assist_event,
  input wire logic float_exception_event,
  output logic [5:0] unit_free,
  output logic div_owner,
  output logic [15:0] tag_ready,
  output logic [1:0] issue_reject,
  output logic [31:0] div_op_count,
  output logic [31:0] div_busy_cycles,
  output logic [31:0] assist_count,
  output logic [31:0] exception_count
);

  // ----------------------------------------
  // Slot view and acceptance
  // ----------------------------------------
  fse_op_t cls [FSE_SLOTS];
  logic [3:0] dest [FSE_SLOTS];
  logic [6:0] dbits [FSE_SLOTS];
  logic thr [FSE_SLOTS];
  logic [1:0] acc;
  logic [4:0] ufree;
  logic div_free;
  logic div_start;
  logic div_thread;
  logic [7:0] div_lat;
  logic [4:0] u_issue;
  logic [7:0] u_intv [5];
  logic [7:0] ucnt [5];
  logic [7:0] sb_cnt [FSE_NUM_TAGS];
  logic [7:0] sb_ld [FSE_NUM_TAGS];
  logic [FSE_NUM_TAGS-1:0] sb_hit;

  assign cls[0] = iss_class0;
  assign cls[1] = iss_class1;
  assign dest[0] = iss_dest0;
  assign dest[1] = iss_dest1;
  assign dbits[0] = iss_div_bits0;
  assign dbits[1] = iss_div_bits1;
  assign thr[0] = iss_thread0;
  assign thr[1] = iss_thread1;

  always_comb begin
    logic [1:0] used [FSE_NUM_UNITS];
    fse_unit_t u;
    logic ok;
    u = FSE_U_VALU;
    ok = 1'b0;
    for (int k = 0; k < FSE_NUM_UNITS; k++) begin
      used[k] = 2'h0;
    end
    acc = 2'b00;
    u_issue = 5'h00;
    div_start = 1'b0;
    div_thread = 1'b0;
    div_lat = 8'h01;
    for (int k = 0; k < 5; k++) begin
      u_intv[k] = 8'h01;
    end
    for (int s = 0; s < FSE_SLOTS; s++) begin
      u = fse_op_unit(cls[s]);
      ok = (u == FSE_U_DIV) ? div_free : ufree[u];
      ok = ok && (used[u] < fse_unit_count(u));
      if (iss_valid[s] && ok) begin
        acc[s] = 1'b1;
        used[u] = used[u] + 2'h1;
        if (u == FSE_U_DIV) begin
          div_start = 1'b1;
          div_thread = thr[s];
          div_lat = fse_op_lat(cls[s], dbits[s]);
        end else begin
          u_issue[u] = 1'b1;
          u_intv[u] = fse_op_intv(cls[s], dbits[s]);
        end
      end
    end
  end

  // ----------------------------------------
  // Per-unit issue interval
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < 5; k++) begin
        ucnt[k] <= 8'h00;
      end
      ufree <= 5'h1F;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (u_issue[k]) begin
          ucnt[k] <= u_intv[k] - 8'h01;
          ufree[k] <= (u_intv[k] == 8'h01);
        end else if (ucnt[k] != 8'h00) begin
          ucnt[k] <= ucnt[k] - 8'h01;
          ufree[k] <= (ucnt[k] == 8'h01);
        end
      end
    end
  end

  fse_div_unit u_div (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(div_start),
    .start_thread(div_thread),
    .start_lat(div_lat),
    .free(div_free),
    .owner(div_owner)
  );

  assign unit_free = {div_free, ufree};

  // ----------------------------------------
  // Result scoreboard per destination tag
  // ----------------------------------------
  always_comb begin
    for (int t = 0; t < FSE_NUM_TAGS; t++) begin
      sb_ld[t] = 8'h00;
      sb_hit[t] = 1'b0;
      for (int s = 0; s < FSE_SLOTS; s++) begin
        if (acc[s] && dest[s] == 4'(t)) begin
          sb_hit[t] = 1'b1;
          sb_ld[t] = fse_op_lat(cls[s], dbits[s]) - 8'h01
            + (fse_op_fp(cls[s]) ? FSE_FP_EXTRA : 8'h00);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int t = 0; t < FSE_NUM_TAGS; t++) begin
        sb_cnt[t] <= 8'h00;
      end
      tag_ready <= 16'hFFFF;
    end else begin
      for (int t = 0; t < FSE_NUM_TAGS; t++) begin
        if (sb_hit[t]) begin
          sb_cnt[t] <= sb_ld[t];
          tag_ready[t] <= (sb_ld[t] == 8'h00);
        end else if (sb_cnt[t] != 8'h00) begin
          sb_cnt[t] <= sb_cnt[t] - 8'h01;
          tag_ready[t] <= (sb_cnt[t] == 8'h01);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      issue_reject <= 2'b00;
    end else begin
      issue_reject <= iss_valid & ~acc;
    end
  end

  // ----------------------------------------
  // Event counts
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_op_count <= 32'h0000_0000;
      div_busy_cycles <= 32'h0000_0000;
    end else begin
      if (div_start) begin
        div_op_count <= div_op_count + 32'h0000_0001;
      end
      if (div_start || !div_free) begin
        div_busy_cycles <= div_busy_cycles + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      assist_count <= 32'h0000_0000;
      exception_count <= 32'h0000_0000;
    end else begin
      if (float_assist_event) begin
        assist_count <= assist_count + 32'h0000_0001;
      end
      if (float_exception_event) begin
        exception_count <= exception_count + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_valu_dual;
    @(posedge mclk) disable iff (!arst_n)
    (iss_valid == 2'b11 && fse_op_unit(iss_class0) == FSE_U_VALU
      && fse_op_unit(iss_class1) == FSE_U_VALU) |=> issue_reject == 2'b00;
  endproperty
  a_valu_dual: assert property (p_valu_dual) else $error("two vector ALU ops refused");

  property p_fadd_lat;
    @(posedge mclk) disable iff (!arst_n)
    (acc[0] && iss_class0 == FSE_OP_FADD_PS && !(acc[1] && iss_dest1 == iss_dest0))
      |=> sb_cnt[$past(iss_dest0)] == 8'h06;
  endproperty
  a_fadd_lat: assert property (p_fadd_lat) else $error("fp add hold wrong");

  property p_faddpd_intv;
    @(posedge mclk) disable iff (!arst_n)
    (acc[0] && iss_class0 == FSE_OP_FADD_PD) |=> !unit_free[FSE_U_FADD] [*4] ##1
      unit_free[FSE_U_FADD];
  endproperty
  a_faddpd_intv: assert property (p_faddpd_intv) else $error("packed add interval wrong");

  property p_fmulpd_intv;
    @(posedge mclk) disable iff (!arst_n)
    (acc[0] && iss_class0 == FSE_OP_FMUL_PD) |=> !unit_free[FSE_U_FMUL] [*8] ##1
      unit_free[FSE_U_FMUL];
  endproperty
  a_fmulpd_intv: assert property (p_fmulpd_intv) else $error("packed mul interval wrong");

  property p_vmul_lat;
    @(posedge mclk) disable iff (!arst_n)
    (acc[0] && iss_class0 == FSE_OP_VMUL128 && !(acc[1] && iss_dest1 == iss_dest0))
      |=> sb_cnt[$past(iss_dest0)] == 8'h04 && !unit_free[FSE_U_FMUL] ##1 unit_free[FSE_U_FMUL];
  endproperty
  a_vmul_lat: assert property (p_vmul_lat) else $error("vector mul timing wrong");

  property p_div_lat;
    @(posedge mclk) disable iff (!arst_n)
    (acc[0] && iss_class0 == FSE_OP_FDIV && !(acc[1] && iss_dest1 == iss_dest0))
      |=> sb_cnt[$past(iss_dest0)] == fse_div_lat($past(iss_div_bits0)) + 8'h01;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divide hold wrong");

  property p_div_share;
    @(posedge mclk) disable iff (!arst_n)
    (!div_free && iss_valid[0] && iss_class0 == FSE_OP_FDIV) |=> issue_reject[0];
  endproperty
  a_div_share: assert property (p_div_share) else $error("busy divider took an op");

  property p_div_count;
    @(posedge mclk) disable iff (!arst_n)
    div_start |=> div_op_count == $past(div_op_count) + 32'h0000_0001;
  endproperty
  a_div_count: assert property (p_div_count) else $error("divide count missed");

  property p_busy_count;
    @(posedge mclk) disable iff (!arst_n)
    !div_free |=> div_busy_cycles == $past(div_busy_cycles) + 32'h0000_0001;
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("busy cycle count missed");

  property p_assist_count;
    @(posedge mclk) disable iff (!arst_n)
    float_assist_event |=> assist_count == $past(assist_count) + 32'h0000_0001;
  endproperty
  a_assist_count: assert property (p_assist_count) else $error("assist count missed");

  property p_unit_block;
    @(posedge mclk) disable iff (!arst_n)
    (!unit_free[FSE_U_FMUL] && iss_valid[0] && fse_op_unit(iss_class0) == FSE_U_FMUL)
      |=> issue_reject[0];
  endproperty
  a_unit_block: assert property (p_unit_block) else $error("busy multiplier took an op");

endmodule : fse_exec_timing

`default_nettype wire

//--- pkg/fse_pkg.sv
// Shared constants, types and timing functions of the FP/vector issue timing block
package fse_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int FSE_SLOTS = 2;
  localparam int FSE_NUM_TAGS = 16;
  localparam int FSE_TAG_W = 4;
  localparam int FSE_CNT_W = 8;
  localparam int FSE_DIVB_W = 7;
  localparam int FSE_STAT_W = 32;
  localparam int FSE_NUM_UNITS = 6;

  // ----------------------------------------
  // Latency and issue interval, in cycles
  // ----------------------------------------
  localparam logic [7:0] FSE_LAT_VALU = 8'h01;
  localparam logic [7:0] FSE_INT_VALU = 8'h01;
  localparam logic [1:0] FSE_NUM_VALU = 2'h2;
  localparam logic [7:0] FSE_LAT_VSHIFT = 8'h01;
  localparam logic [7:0] FSE_INT_VSHIFT = 8'h01;
  localparam logic [7:0] FSE_LAT_VSHUF = 8'h01;
  localparam logic [7:0] FSE_INT_VSHUF = 8'h01;
  localparam logic [7:0] FSE_LAT_FADD = 8'h05;
  localparam logic [7:0] FSE_INT_FADD = 8'h01;
  localparam logic [7:0] FSE_LAT_FADD_PD = 8'h06;
  localparam logic [7:0] FSE_INT_FADD_PD = 8'h05;
  localparam logic [7:0] FSE_LAT_VMUL128 = 8'h05;
  localparam logic [7:0] FSE_INT_VMUL128 = 8'h02;
  localparam logic [7:0] FSE_LAT_VMUL64 = 8'h04;
  localparam logic [7:0] FSE_INT_VMUL64 = 8'h01;
  localparam logic [7:0] FSE_LAT_FMUL_X87 = 8'h05;
  localparam logic [7:0] FSE_INT_FMUL_X87 = 8'h02;
  localparam logic [7:0] FSE_LAT_FMUL_SS = 8'h04;
  localparam logic [7:0] FSE_INT_FMUL_SS = 8'h01;
  localparam logic [7:0] FSE_LAT_FMUL_SD = 8'h05;
  localparam logic [7:0] FSE_INT_FMUL_SD = 8'h02;
  localparam logic [7:0] FSE_LAT_FMUL_PS = 8'h05;
  localparam logic [7:0] FSE_INT_FMUL_PS = 8'h02;
  localparam logic [7:0] FSE_LAT_FMUL_PD = 8'h09;
  localparam logic [7:0] FSE_INT_FMUL_PD = 8'h09;
  localparam logic [7:0] FSE_FP_EXTRA = 8'h02;
  localparam logic [7:0] FSE_DIV_SETUP = 8'h02;
  localparam logic [7:0] FSE_DIV_BITS_MAX = 8'h40;

  typedef enum logic [4:0] {
    FSE_OP_VALU128, FSE_OP_VALU64, FSE_OP_VSHIFT128, FSE_OP_VSHIFT64,
    FSE_OP_VSHUF128, FSE_OP_VSHUF64, FSE_OP_VMUL128, FSE_OP_VMUL64,
    FSE_OP_FADD_X87, FSE_OP_FADD_SCALAR, FSE_OP_FADD_PS, FSE_OP_FADD_PD,
    FSE_OP_FMUL_X87, FSE_OP_FMUL_SS, FSE_OP_FMUL_SD, FSE_OP_FMUL_PS,
    FSE_OP_FMUL_PD, FSE_OP_FDIV
  } fse_op_t;

  typedef enum logic [2:0] {
    FSE_U_VALU, FSE_U_VSHIFT, FSE_U_VSHUF, FSE_U_FADD, FSE_U_FMUL, FSE_U_DIV
  } fse_unit_t;

  // ----------------------------------------
  // Timing functions
  // ----------------------------------------
  function automatic fse_unit_t fse_op_unit(input fse_op_t op);
    case (op)
      FSE_OP_VALU128, FSE_OP_VALU64: fse_op_unit = FSE_U_VALU;
      FSE_OP_VSHIFT128, FSE_OP_VSHIFT64: fse_op_unit = FSE_U_VSHIFT;
      FSE_OP_VSHUF128, FSE_OP_VSHUF64: fse_op_unit = FSE_U_VSHUF;
      FSE_OP_FADD_X87, FSE_OP_FADD_SCALAR, FSE_OP_FADD_PS, FSE_OP_FADD_PD:
        fse_op_unit = FSE_U_FADD;
      FSE_OP_FDIV: fse_op_unit = FSE_U_DIV;
      default: fse_op_unit = FSE_U_FMUL;
    endcase
  endfunction : fse_op_unit

  // Radix-2: one quotient bit per cycle plus setup
  function automatic logic [7:0] fse_div_lat(input logic [6:0] bits);
    logic [7:0] b;
    b = {1'b0, bits};
    if (b == 8'h00) begin
      b = 8'h01;
    end else if (b > FSE_DIV_BITS_MAX) begin
      b = FSE_DIV_BITS_MAX;
    end
    fse_div_lat = b + FSE_DIV_SETUP;
  endfunction : fse_div_lat

  function automatic logic [7:0] fse_op_lat(input fse_op_t op, input logic [6:0] bits);
    case (op)
      FSE_OP_VALU128, FSE_OP_VALU64: fse_op_lat = FSE_LAT_VALU;
      FSE_OP_VSHIFT128, FSE_OP_VSHIFT64: fse_op_lat = FSE_LAT_VSHIFT;
      FSE_OP_VSHUF128, FSE_OP_VSHUF64: fse_op_lat = FSE_LAT_VSHUF;
      FSE_OP_VMUL128: fse_op_lat = FSE_LAT_VMUL128;
      FSE_OP_VMUL64: fse_op_lat = FSE_LAT_VMUL64;
      FSE_OP_FADD_PD: fse_op_lat = FSE_LAT_FADD_PD;
      FSE_OP_FMUL_X87: fse_op_lat = FSE_LAT_FMUL_X87;
      FSE_OP_FMUL_SS: fse_op_lat = FSE_LAT_FMUL_SS;
      FSE_OP_FMUL_SD: fse_op_lat = FSE_LAT_FMUL_SD;
      FSE_OP_FMUL_PS: fse_op_lat = FSE_LAT_FMUL_PS;
      FSE_OP_FMUL_PD: fse_op_lat = FSE_LAT_FMUL_PD;
      FSE_OP_FDIV: fse_op_lat = fse_div_lat(bits);
      default: fse_op_lat = FSE_LAT_FADD;
    endcase
  endfunction : fse_op_lat

  function automatic logic [7:0] fse_op_intv(input fse_op_t op, input logic [6:0] bits);
    case (op)
      FSE_OP_VMUL128: fse_op_intv = FSE_INT_VMUL128;
      FSE_OP_VMUL64: fse_op_intv = FSE_INT_VMUL64;
      FSE_OP_FADD_PD: fse_op_intv = FSE_INT_FADD_PD;
      FSE_OP_FMUL_X87: fse_op_intv = FSE_INT_FMUL_X87;
      FSE_OP_FMUL_SS: fse_op_intv = FSE_INT_FMUL_SS;
      FSE_OP_FMUL_SD: fse_op_intv = FSE_INT_FMUL_SD;
      FSE_OP_FMUL_PS: fse_op_intv = FSE_INT_FMUL_PS;
      FSE_OP_FMUL_PD: fse_op_intv = FSE_INT_FMUL_PD;
      FSE_OP_FDIV: fse_op_intv = fse_div_lat(bits);
      default: fse_op_intv = FSE_INT_VALU;
    endcase
  endfunction : fse_op_intv

  // Results that consumers see two cycles late
  function automatic logic fse_op_fp(input fse_op_t op);
    fse_op_fp = (op >= FSE_OP_FADD_X87);
  endfunction : fse_op_fp

  function automatic logic [1:0] fse_unit_count(input fse_unit_t u);
    fse_unit_count = (u == FSE_U_VALU) ? FSE_NUM_VALU : 2'h1;
  endfunction : fse_unit_count

endpackage : fse_pkg

//--- sim/fse_sched_model.sv
// Scheduler model driving slot 0 of the FP/vector issue port
`timescale 1ns/100ps
`default_nettype none

module fse_sched_model
  import fse_pkg::*;
(
  input wire logic mclk,
  input wire logic [5:0] unit_free,
  input wire logic [15:0] tag_ready,
  output logic valid,
  output fse_op_t op,
  output logic thread,
  output logic [3:0] dest,
  output logic [6:0] bits
);
  initial begin
    valid = 1'b0;
    op = FSE_OP_VALU128;
    thread = 1'b0;
    dest = 4'h0;
    bits = 7'h00;
  end

  // ----------------------------------------
  // One request, held over one taking edge
  // ----------------------------------------
  task automatic issue(input fse_op_t o, input logic [2:0] u, input logic [3:0] d,
                       input logic t, input logic [6:0] b, input logic obey);
    int n;
    n = 0;
    @(negedge mclk);
    while (obey && !(unit_free[u] === 1'b1 && tag_ready[d] === 1'b1) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    valid = 1'b1;
    op = o;
    dest = d;
    thread = t;
    bits = b;
    @(posedge mclk);
    @(negedge mclk);
    valid = 1'b0;
    dest = ~d;
    thread = ~t;
    bits = ~b;
  endtask : issue
endmodule : fse_sched_model

`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the FP/vector issue timing block
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import fse_pkg::*;
;
  // Per entry, entry 0 in the low bits: unit, interval, latency seen by consumers
  localparam logic [75:0] T_UNIT = 76'h5544444333344221100;
  localparam logic [151:0] T_INTV = 152'h42030902020102050101010102010101010101;
  localparam logic [151:0] T_LAT = 152'h44050B07070607080707070405010101010101;
  logic mclk;
  logic arst_n;
  logic m_valid, m_thread, s1_valid, s1_thread, float_assist_event, float_exception_event;
  fse_op_t m_op, s1_op;
  logic [3:0] m_dest, s1_dest;
  logic [6:0] m_bits, s1_bits;
  logic [5:0] unit_free;
  logic div_owner;
  logic [15:0] tag_ready;
  logic [1:0] issue_reject;
  logic [31:0] div_op_count, div_busy_cycles, assist_count, exception_count;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  fse_exec_timing u_fse_exec_timing (
    .mclk(mclk), .arst_n(arst_n), .iss_valid({s1_valid, m_valid}),
    .iss_class0(m_op), .iss_class1(s1_op), .iss_thread0(m_thread), .iss_thread1(s1_thread),
    .iss_dest0(m_dest), .iss_dest1(s1_dest), .iss_div_bits0(m_bits), .iss_div_bits1(s1_bits),
    .float_assist_event(float_assist_event), .float_exception_event(float_exception_event),
    .unit_free(unit_free), .div_owner(div_owner), .tag_ready(tag_ready),
    .issue_reject(issue_reject), .div_op_count(div_op_count),
    .div_busy_cycles(div_busy_cycles), .assist_count(assist_count),
    .exception_count(exception_count)
  );

  fse_sched_model u_fse_sched_model (
    .mclk(mclk), .unit_free(unit_free), .tag_ready(tag_ready), .valid(m_valid),
    .op(m_op), .thread(m_thread), .dest(m_dest), .bits(m_bits)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      results();
    end
  end

  task automatic chk_reset();
    chk({26'h0, unit_free}, 32'h3F);
    chk({16'h0, tag_ready}, 32'hFFFF);
    chk({29'h0, div_owner, issue_reject}, 32'h0);
    chk(div_op_count | div_busy_cycles | assist_count | exception_count, 32'h0);
  endtask : chk_reset

  task automatic wait_idle();
    for (int k = 0; k < 100 && !(unit_free === 6'h3F && tag_ready === 16'hFFFF); k++) begin
      @(negedge mclk);
    end
    chk({10'h0, unit_free, tag_ready}, 32'h003F_FFFF);
  endtask : wait_idle

  // Slot 1 request held over one edge; returns the refusal flags
  task automatic s1(input fse_op_t o, input logic [3:0] d, input logic t, output logic [1:0] r);
    @(negedge mclk);
    s1_valid = 1'b1;
    s1_op = o;
    s1_dest = d;
    s1_thread = t;
    s1_bits = 7'h0A;
    @(posedge mclk);
    @(negedge mclk);
    r = issue_reject;
    s1_valid = 1'b0;
    s1_dest = ~d;
    s1_thread = ~t;
    s1_bits = 7'h75;
  endtask : s1

  task automatic pair(input fse_op_t o0, input fse_op_t o1, input logic [1:0] exp);
    logic [1:0] r;
    fork
      u_fse_sched_model.issue(o0, 3'h0, 4'h6, 1'b0, 7'h00, 1'b0);
      s1(o1, 4'h7, 1'b0, r);
    join
    chk({30'h0, r}, {30'h0, exp});
    wait_idle();
  endtask : pair

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_timing();
    logic [7:0] nu, nt, ei, el;
    logic [2:0] u;
    for (int i = 0; i < 19; i++) begin
      u = T_UNIT[4*i +: 3];
      ei = T_INTV[8*i +: 8];
      el = T_LAT[8*i +: 8];
      nu = 8'h00;
      nt = 8'h00;
      u_fse_sched_model.issue(fse_op_t'((i > 17) ? 17 : i), u, i[3:0], i[0],
                              (i == 18) ? 7'h64 : 7'h00, 1'b1);
      for (int k = 0; k < 80; k++) begin
        nu += {7'h00, ~unit_free[u]};
        nt += {7'h00, ~tag_ready[i[3:0]]};
        @(negedge mclk);
      end
      chk({24'h0, nu}, {24'h0, ei - 8'h01});
      chk({24'h0, nt}, {24'h0, el - 8'h01});
      if (u == 3'h5) chk({31'h0, div_owner}, {31'h0, i[0]});
    end
    chk(div_op_count, 32'h2);
    chk(div_busy_cycles, 32'h45);
  endtask : t_timing

  task automatic t_refuse();
    logic [1:0] r;
    u_fse_sched_model.issue(FSE_OP_FDIV, 3'h5, 4'h3, 1'b0, 7'h0A, 1'b1);
    s1(FSE_OP_FDIV, 4'h4, 1'b1, r);
    chk({30'h0, r}, 32'h2);
    chk(div_op_count, 32'h3);
    chk({31'h0, div_owner}, 32'h0);
    wait_idle();
    chk(div_busy_cycles, 32'h51);
    s1(FSE_OP_FDIV, 4'h4, 1'b1, r);
    chk({30'h0, r}, 32'h0);
    u_fse_sched_model.issue(FSE_OP_FDIV, 3'h5, 4'h5, 1'b0, 7'h0A, 1'b0);
    chk({30'h0, issue_reject}, 32'h1);
    chk({31'h0, div_owner}, 32'h1);
    chk(div_op_count, 32'h4);
    wait_idle();
    u_fse_sched_model.issue(FSE_OP_FMUL_PD, 3'h4, 4'h3, 1'b0, 7'h00, 1'b1);
    s1(FSE_OP_FMUL_SS, 4'h4, 1'b0, r);
    chk({30'h0, r}, 32'h2);
    u_fse_sched_model.issue(FSE_OP_FMUL_SS, 3'h4, 4'h5, 1'b0, 7'h00, 1'b0);
    chk({30'h0, issue_reject}, 32'h1);
    wait_idle();
    pair(FSE_OP_VALU128, FSE_OP_VALU64, 2'h0);
    pair(FSE_OP_VSHIFT64, FSE_OP_VSHIFT128, 2'h2);
    pair(FSE_OP_VSHUF64, FSE_OP_VSHUF128, 2'h2);
    pair(FSE_OP_FADD_X87, FSE_OP_FADD_PS, 2'h2);
  endtask : t_refuse

  task automatic t_events();
    @(negedge mclk);
    float_assist_event = 1'b1;
    @(negedge mclk);
    chk(assist_count, 32'h1);
    float_exception_event = 1'b1;
    repeat (2) @(negedge mclk);
    float_assist_event = 1'b0;
    float_exception_event = 1'b0;
    @(negedge mclk);
    chk(assist_count, 32'h3);
    chk(exception_count, 32'h2);
  endtask : t_events

  initial begin
    arst_n = 1'b0;
    s1_valid = 1'b0;
    s1_op = FSE_OP_VALU128;
    s1_dest = 4'h0;
    s1_thread = 1'b0;
    s1_bits = 7'h00;
    float_assist_event = 1'b0;
    float_exception_event = 1'b0;
    repeat (5) @(negedge mclk);
    chk_reset();
    arst_n = 1'b1;
    @(negedge mclk);
    chk_reset();
    $display("test reset done");
    t_timing();
    $display("test timing done");
    t_refuse();
    $display("test refuse done");
    t_events();
    $display("test events done");
    u_fse_sched_model.issue(FSE_OP_FMUL_PD, 3'h4, 4'h9, 1'b0, 7'h00, 1'b1);
    arst_n = 1'b0;
    #1;
    chk_reset();
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    chk_reset();
    $display("test midrun reset done");
    results();
  end
endmodule : tb_top

`default_nettype wire
